/* File: design/cddc_host.sv */
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "cddc_defines.svh"

module cddc_host #(
   parameter int HALF_CYC = `CDDC_PROG_HALF_CYC,
   parameter int SYNC_LOW_CYC = `CDDC_SYNC_LOW_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   cddc_link_if.host link,
   input wire logic [3:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [3:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   typedef struct packed {
      logic aw_have;
      logic [3:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      cddc_pkg::cddc_ser_st_t st;
      logic [31:0] word;
      logic [4:0] bitn;
      logic [7:0] timer;
      logic pclk;
      logic pdata;
      logic platch;
      logic goe_level;
      logic goe_drive;
      logic [7:0] sync_cnt;
   } cddc_host_st_t;

   cddc_host_st_t q;
   cddc_host_st_t n;

   // Bus slave, serial engine and pin drivers
   always_comb
   begin
      logic [31:0] merged;
      logic busy;
      n = q;
      merged = q.word;
      busy = q.st != cddc_pkg::CDDC_ST_IDLE;
      for (int b = 0; b < 4; b++)
      begin
         if (q.w_strb[b])
         begin
            merged[b*8 +: 8] = q.w_data[b*8 +: 8];
         end
      end

      // Address and data taken in either order
      if (i_awvalid && o_awready)
      begin
         n.aw_have = 1'h1;
         n.aw_addr = i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
         n.w_have = 1'h1;
         n.w_data = i_wdata;
         n.w_strb = i_wstrb;
      end
      if (q.bvalid && i_bready)
      begin
         n.bvalid = 1'h0;
      end

      // Serial engine: bit cells, then latch pulse, then lines low
      case (q.st)
         cddc_pkg::CDDC_ST_IDLE:
         begin
            n.pclk = 1'h0;
            n.platch = 1'h0;
            n.pdata = 1'h0;
         end
         cddc_pkg::CDDC_ST_LOW:
         begin
            if (q.timer != 8'h00)
            begin
               n.timer = q.timer - 8'h01;
            end
            else
            begin
               n.st = cddc_pkg::CDDC_ST_HIGH;
               n.pclk = 1'h1;
               n.timer = 8'(HALF_CYC - 1);
            end
         end
         cddc_pkg::CDDC_ST_HIGH:
         begin
            if (q.timer != 8'h00)
            begin
               n.timer = q.timer - 8'h01;
            end
            else if (q.bitn == 5'h00)
            begin
               n.st = cddc_pkg::CDDC_ST_LATCH;
               n.pclk = 1'h0;
               n.platch = 1'h1;
               n.timer = 8'(HALF_CYC - 1);
            end
            else
            begin
               n.st = cddc_pkg::CDDC_ST_LOW;
               n.pclk = 1'h0;
               n.bitn = q.bitn - 5'h01;
               n.pdata = q.word[q.bitn - 5'h01];
               n.timer = 8'(HALF_CYC - 1);
            end
         end
         cddc_pkg::CDDC_ST_LATCH:
         begin
            if (q.timer != 8'h00)
            begin
               n.timer = q.timer - 8'h01;
            end
            else
            begin
               n.st = cddc_pkg::CDDC_ST_IDLE;
               n.platch = 1'h0;
               n.pdata = 1'h0;
            end
         end
         default:
         begin
            n.st = cddc_pkg::CDDC_ST_IDLE;
         end
      endcase

      // Sync low pulse countdown
      if (q.sync_cnt != 8'h00)
      begin
         n.sync_cnt = q.sync_cnt - 8'h01;
      end

      // Write executes once both halves are held
      if (q.aw_have && q.w_have && !q.bvalid)
      begin
         n.aw_have = 1'h0;
         n.w_have = 1'h0;
         n.bvalid = 1'h1;
         n.bresp = `CDDC_RESP_OKAY;
         if (q.aw_addr == `CDDC_HOST_WORD && !busy)
         begin
            n.word = merged;
            n.st = cddc_pkg::CDDC_ST_LOW;
            n.bitn = 5'h1F;
            n.pdata = merged[31];
            n.pclk = 1'h0;
            n.platch = 1'h0;
            n.timer = 8'(HALF_CYC - 1);
         end
         else if (q.aw_addr == `CDDC_HOST_CTRL)
         begin
            if (q.w_strb[0])
            begin
               n.goe_level = q.w_data[`CDDC_CTRL_GOE_LEVEL];
               n.goe_drive = q.w_data[`CDDC_CTRL_GOE_DRIVE];
               if (q.w_data[`CDDC_CTRL_SYNC_GO])
               begin
                  n.sync_cnt = 8'(SYNC_LOW_CYC);
               end
            end
         end
         else
         begin
            n.bresp = `CDDC_RESP_SLVERR;
         end
      end

      // Read answer one cycle after the address is taken
      if (q.rvalid && i_rready)
      begin
         n.rvalid = 1'h0;
      end
      if (i_arvalid && o_arready)
      begin
         n.rvalid = 1'h1;
         n.rresp = `CDDC_RESP_OKAY;
         n.rdata = 32'h00000000;
         case (i_araddr)
            `CDDC_HOST_WORD: n.rdata = q.word;
            `CDDC_HOST_CTRL: n.rdata = {30'h00000000, q.goe_drive, q.goe_level};
            `CDDC_HOST_STATUS: n.rdata = {30'h00000000, q.sync_cnt != 8'h00, busy};
            default: n.rresp = `CDDC_RESP_SLVERR;
         endcase
      end
   end

   // State register
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         q <= '0;
         q.st <= cddc_pkg::CDDC_ST_IDLE;
         q.goe_level <= `CDDC_DEF_GOE_LEVEL;
         q.goe_drive <= `CDDC_DEF_GOE_DRIVE;
      end
      else
      begin
         q <= n;
      end
   end

   assign o_awready = !q.aw_have && !q.bvalid;
   assign o_wready = !q.w_have && !q.bvalid;
   assign o_bvalid = q.bvalid;
   assign o_bresp = q.bresp;
   assign o_arready = !q.rvalid;
   assign o_rvalid = q.rvalid;
   assign o_rdata = q.rdata;
   assign o_rresp = q.rresp;
   assign link.prog_clock = q.pclk;
   assign link.prog_serial_in = q.pdata;
   assign link.prog_latch_strobe = q.platch;
   assign link.sync_n_drv = 1'h0;
   assign link.sync_n_oe = q.sync_cnt != 8'h00;
   assign link.all_out_enable_drv = q.goe_level;
   assign link.all_out_enable_oe = q.goe_drive;
endmodule

/* File: shared/cddc_defines.svh */
`ifndef CDDC_DEFINES_SVH
`define CDDC_DEFINES_SVH

// Programming word layout
`define CDDC_WORD_BITS 32
`define CDDC_ADDR_MSB 3
`define CDDC_DLY_LSB 4
`define CDDC_DLY_MSB 7
`define CDDC_DIV_LSB 8
`define CDDC_DIV_MSB 15
`define CDDC_EN_BIT 16
`define CDDC_MUX_LSB 17
`define CDDC_MUX_MSB 18
`define CDDC_GLOB_EN_BIT 27
`define CDDC_REF_SEL_BIT 29
`define CDDC_RESET_BIT 31
`define CDDC_ADDR_R0 4'h0
`define CDDC_ADDR_R14 4'hE

// Channel structure
`define CDDC_NUM_CHAN 8
`define CDDC_DLY_STEP_PS 150
`define CDDC_DLY_MAX_PS 2250
`define CDDC_DLY_TAPS (`CDDC_DLY_MAX_PS / `CDDC_DLY_STEP_PS)
`define CDDC_SYNC_LAT 4

// Power-on defaults
`define CDDC_DEF_DLY 4'h0
`define CDDC_DEF_DIV 8'h01
`define CDDC_DEF_EN 1'h0
`define CDDC_DEF_MUX 2'h0
`define CDDC_DEF_GLOB_EN 1'h1
`define CDDC_DEF_REF_SEL 1'h0

// Host timing and register map
`define CDDC_CLK_PERIOD_NS 40
`define CDDC_PROG_HALF_NS 25
`define CDDC_PROG_HALF_CYC ((`CDDC_PROG_HALF_NS + `CDDC_CLK_PERIOD_NS - 1) / `CDDC_CLK_PERIOD_NS)
`define CDDC_SYNC_LOW_CYC 16
`define CDDC_HOST_WORD 4'h0
`define CDDC_HOST_CTRL 4'h4
`define CDDC_HOST_STATUS 4'h8
`define CDDC_CTRL_GOE_LEVEL 0
`define CDDC_CTRL_GOE_DRIVE 1
`define CDDC_CTRL_SYNC_GO 2
`define CDDC_DEF_GOE_LEVEL 1'h1
`define CDDC_DEF_GOE_DRIVE 1'h0
`define CDDC_RESP_OKAY 2'h0
`define CDDC_RESP_SLVERR 2'h2

`endif

/* File: shared/cddc_pkg.sv */
package cddc_pkg;
   // Channel source selection
   typedef enum logic [1:0] {
      CDDC_MUX_BYPASS = 2'h0,
      CDDC_MUX_DIVIDED = 2'h1,
      CDDC_MUX_DELAYED = 2'h2,
      CDDC_MUX_DIV_DLY = 2'h3
   } cddc_mux_t;

   // Serial engine states, Gray along idle-low-high-latch-idle
   typedef enum logic [1:0] {
      CDDC_ST_IDLE = 2'h0,
      CDDC_ST_LOW = 2'h1,
      CDDC_ST_HIGH = 2'h3,
      CDDC_ST_LATCH = 2'h2
   } cddc_ser_st_t;
endpackage

/* File: shared/cddc_link_if.sv */
`timescale 1ns/1ps
interface cddc_link_if;
   logic prog_clock;
   logic prog_serial_in;
   logic prog_latch_strobe;
   logic sync_n_drv;
   logic sync_n_oe;
   logic all_out_enable_drv;
   logic all_out_enable_oe;
   logic sync_n;
   logic all_out_enable_pin;

   // Pull-ups: an undriven pin reads high
   assign sync_n = sync_n_oe ? sync_n_drv : 1'h1;
   assign all_out_enable_pin = all_out_enable_oe ? all_out_enable_drv : 1'h1;

   modport device (
      input prog_clock,
      input prog_serial_in,
      input prog_latch_strobe,
      input sync_n,
      input all_out_enable_pin
   );
   modport host (
      output prog_clock,
      output prog_serial_in,
      output prog_latch_strobe,
      output sync_n_drv,
      output sync_n_oe,
      output all_out_enable_drv,
      output all_out_enable_oe
   );
endinterface

/* File: design/cddc_device.sv */
`timescale 1ns/1ps
`include "cddc_defines.svh"

// Summary of operation
// - Eight channels: divider, sync, delay, mux, output
// - Register bit selects reference input a or b
// - Delay steps of 150 ps up to 2250
// - Channel enable clear turns that output off
// - Channel, global bit and pin enables combined
// - Global bit or pin low stops all outputs
// - Enabled channel with pin low drives static low
// - Enable pin pulled up when left open
// - Sync low holds divided outputs low
// - Sync release restarts divided outputs together high
// - Bypass channels ignore sync, stay aligned
// - Controller holds sync low over one reference cycle
// - Outputs go low four cycles after sync registered
// - Outputs rise five cycles after sync rises
// - Sync pin pulled up, outputs run undriven
// - Reset loads every register with defaults
// - Word is 28 data bits, 4 address bits
// - Shift MSB first on clock rise, strobe low
// - Strobe rise copies word to addressed register
// - Controller writes registers 0-7 and 14
// - Register 0 reset bit set ignores other bits
// - Controller returns link lines low when done
module cddc_device #(
   parameter int NCH = `CDDC_NUM_CHAN
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   cddc_link_if.device link,
   input wire logic i_ref_input_a,
   input wire logic i_ref_input_b,
   output logic [NCH-1:0] o_chan_out,
   output logic [NCH-1:0] o_chan_drive,
   output logic o_ref_sel
);
   localparam int TAPS = `CDDC_DLY_TAPS;

   typedef struct packed {
      logic clk_p;
      logic latch_p;
      logic [`CDDC_WORD_BITS-1:0] shift;
      logic [NCH-1:0][3:0] dly;
      logic [NCH-1:0][7:0] div;
      logic [NCH-1:0] en;
      logic [NCH-1:0][1:0] mux;
      logic glob_en;
      logic ref_sel;
      logic ref_s;
      logic ref_p;
      logic sync_s;
      logic goe_s;
      logic [`CDDC_SYNC_LAT-1:0] sync_pipe;
      logic [NCH-1:0][7:0] cnt;
      logic [NCH-1:0] pre;
      logic [NCH-1:0][TAPS-1:0] hist;
      logic [NCH-1:0] out;
      logic [NCH-1:0] drive;
   } cddc_dev_st_t;

   cddc_dev_st_t q;
   cddc_dev_st_t n;
   cddc_dev_st_t rst_v;

   // Power-on values, including all programmable fields
   always_comb
   begin
      rst_v = '0;
      for (int i = 0; i < NCH; i++)
      begin
         rst_v.dly[i] = `CDDC_DEF_DLY;
         rst_v.div[i] = `CDDC_DEF_DIV;
         rst_v.en[i] = `CDDC_DEF_EN;
         rst_v.mux[i] = `CDDC_DEF_MUX;
      end
      rst_v.glob_en = `CDDC_DEF_GLOB_EN;
      rst_v.ref_sel = `CDDC_DEF_REF_SEL;
      rst_v.sync_s = 1'h1;
      rst_v.goe_s = 1'h1;
      rst_v.sync_pipe = '1;
   end

   // Next state: serial intake, register load, channel engines
   always_comb
   begin
      logic [`CDDC_ADDR_MSB:0] addr;
      logic [31:0] w;
      logic tick;
      logic held;
      logic [7:0] half;
      logic [TAPS:0] tap;
      logic sel;
      logic dived;
      n = q;
      addr = q.shift[`CDDC_ADDR_MSB:0];
      w = q.shift;
      tick = q.ref_s & ~q.ref_p;
      held = ~q.sync_pipe[`CDDC_SYNC_LAT-1];
      half = 8'h00;
      tap = '0;
      sel = 1'h0;
      dived = 1'h0;

      // Serial shift on sampled clock rise while strobe low
      n.clk_p = link.prog_clock;
      n.latch_p = link.prog_latch_strobe;
      if (!link.prog_latch_strobe && link.prog_clock && !q.clk_p)
      begin
         n.shift = {q.shift[`CDDC_WORD_BITS-2:0], link.prog_serial_in};
      end

      // Strobe rise: address in low nibble, data above
      if (link.prog_latch_strobe && !q.latch_p)
      begin
         if (addr == `CDDC_ADDR_R0 && w[`CDDC_RESET_BIT])
         begin
            n.dly = rst_v.dly;
            n.div = rst_v.div;
            n.en = rst_v.en;
            n.mux = rst_v.mux;
            n.glob_en = rst_v.glob_en;
            n.ref_sel = rst_v.ref_sel;
         end
         else if (addr == `CDDC_ADDR_R14)
         begin
            n.glob_en = w[`CDDC_GLOB_EN_BIT];
            n.ref_sel = w[`CDDC_REF_SEL_BIT];
         end
         else
         begin
            for (int i = 0; i < NCH; i++)
            begin
               if (addr == 4'(i))
               begin
                  n.dly[i] = w[`CDDC_DLY_MSB:`CDDC_DLY_LSB];
                  n.div[i] = w[`CDDC_DIV_MSB:`CDDC_DIV_LSB];
                  n.en[i] = w[`CDDC_EN_BIT];
                  n.mux[i] = w[`CDDC_MUX_MSB:`CDDC_MUX_LSB];
               end
            end
         end
      end

      // Reference pick and rising-edge tick
      n.ref_s = q.ref_sel ? i_ref_input_b : i_ref_input_a;
      n.ref_p = q.ref_s;
      n.goe_s = link.all_out_enable_pin;

      // Sync registered, then four reference cycles of latency
      n.sync_s = link.sync_n;
      if (tick)
      begin
         n.sync_pipe = {q.sync_pipe[`CDDC_SYNC_LAT-2:0], q.sync_s};
      end

      // Per-channel divider, delay tap and output state
      for (int i = 0; i < NCH; i++)
      begin
         dived = q.mux[i][0];
         half = 8'((9'(q.div[i]) + 9'h001) >> 1);
         if (!dived)
         begin
            n.pre[i] = q.ref_s;
         end
         else if (held)
         begin
            n.pre[i] = 1'h0;
            n.cnt[i] = 8'h00;
         end
         else if (q.div[i] <= 8'h01)
         begin
            n.pre[i] = q.ref_s;
         end
         else if (tick)
         begin
            n.pre[i] = q.cnt[i] < half;
            n.cnt[i] = (q.cnt[i] == q.div[i] - 8'h01) ? 8'h00 : q.cnt[i] + 8'h01;
         end
         n.hist[i] = {q.hist[i][TAPS-2:0], q.pre[i]};
         tap = {q.hist[i], q.pre[i]};
         sel = q.mux[i][1] ? tap[q.dly[i]] : q.pre[i];
         if (!q.en[i] || !q.glob_en)
         begin
            n.drive[i] = 1'h0;
            n.out[i] = 1'h0;
         end
         else if (!q.goe_s)
         begin
            n.drive[i] = 1'h1;
            n.out[i] = 1'h0;
         end
         else
         begin
            n.drive[i] = 1'h1;
            n.out[i] = sel;
         end
      end
   end

   // State register
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         q <= rst_v;
      end
      else
      begin
         q <= n;
      end
   end

   assign o_chan_out = q.out;
   assign o_chan_drive = q.drive;
   assign o_ref_sel = q.ref_sel;
endmodule

/* File: testbench/cddc_link_sva.sv */
`timescale 1ns/1ps
module cddc_link_sva (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic prog_clock,
   input wire logic prog_serial_in,
   input wire logic prog_latch_strobe,
   input wire logic sync_n_drv,
   input wire logic sync_n_oe,
   input wire logic sync_n
);
   logic [5:0] rises_q;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   // Serial clock rises seen since the last latch
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || prog_latch_strobe)
         rises_q <= 6'h00;
      else if ($rose(prog_clock))
         rises_q <= rises_q + 6'h01;
   end

   a_idle_after_reset: assert property (disable iff (1'b0)
      i_sys_rst |=> !prog_clock && !prog_latch_strobe) else $error("link not idle after reset");
   a_data_clock_low: assert property ($changed(prog_serial_in) |-> !prog_clock)
      else $error("data moved while serial clock high");
   a_latch_no_clock: assert property (!(prog_latch_strobe && prog_clock))
      else $error("latch and serial clock high together");
   a_latch_after_bit: assert property ($rose(prog_latch_strobe) |-> $fell(prog_clock))
      else $error("latch not right after last bit");
   a_word_length: assert property ($rose(prog_latch_strobe) |-> rises_q == 6'h20)
      else $error("word not 32 bits long");
   a_lines_low_after: assert property ($rose(prog_latch_strobe)
      |=> !prog_latch_strobe && !prog_clock && !prog_serial_in) else $error("lines not low");
   a_clock_high_phase: assert property ($rose(prog_clock) |=> $fell(prog_clock))
      else $error("serial clock high phase wrong");
   a_clock_low_phase: assert property (
      $fell(prog_clock) && !prog_latch_strobe |=> prog_clock)
      else $error("serial clock low phase wrong");
   a_sync_held_low: assert property ($fell(sync_n) |=> !sync_n [*8])
      else $error("sync low too short");
   a_sync_released: assert property ($fell(sync_n) |-> ##[1:200] $rose(sync_n))
      else $error("sync never released");
   a_sync_drive_low: assert property (sync_n_oe |-> !sync_n_drv && !sync_n)
      else $error("sync pin not low while pulled");
   a_sync_pulled_up: assert property (!sync_n_oe |-> sync_n)
      else $error("sync pin low while released");
endmodule

/* File: testbench/clock_divide_distribute_control_test.sv */
`timescale 1ns/1ps
`include "cddc_defines.svh"
module clock_divide_distribute_control_test;
   logic i_sys_clk = 1'h0;
   logic i_sys_rst = 1'h1;
   logic ref_a = 1'h0;
   logic ref_b = 1'h0;
   logic [3:0] awaddr = 4'h0;
   logic awvalid = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic wvalid = 1'h0;
   logic bready = 1'h1;
   logic [3:0] araddr = 4'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h1;
   logic awready, wready, bvalid, arready, rvalid, ref_sel, clk_q, le_q;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, mon_sr, mon_word;
   logic [15:0] out0_hist_q;
   logic [7:0] chan_out, chan_drive;
   logic [15:0] seed = 16'h4F90;
   int mon_cnt = 0;
   int num_errors = 0;
   int comparisons = 0;
   int cyc = 0;

   cddc_link_if link();
   cddc_device cddc_device_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .link(link.device),
      .i_ref_input_a(ref_a), .i_ref_input_b(ref_b), .o_chan_out(chan_out),
      .o_chan_drive(chan_drive), .o_ref_sel(ref_sel));
   cddc_host #(.SYNC_LOW_CYC(48)) cddc_host_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
      .link(link.host), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready));
   cddc_link_sva cddc_link_sva_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
      .prog_clock(link.prog_clock), .prog_serial_in(link.prog_serial_in),
      .prog_latch_strobe(link.prog_latch_strobe), .sync_n_drv(link.sync_n_drv),
      .sync_n_oe(link.sync_n_oe), .sync_n(link.sync_n));

   // Clock
   initial
   begin
      forever #20 i_sys_clk = ~i_sys_clk;
   end

   // References of 4 and 6 cycles, timeout counter
   always @(posedge i_sys_clk)
   begin
      cyc <= cyc + 1;
      ref_a <= cyc[1];
      ref_b <= (cyc % 6) < 3;
      if (cyc == 20000)
      begin
         num_errors++;
         end_sim();
      end
   end

   // Rebuild each serial word from the wire
   always @(posedge i_sys_clk)
   begin
      if (link.prog_clock && !clk_q && !link.prog_latch_strobe)
         mon_sr <= {mon_sr[30:0], link.prog_serial_in};
      if (link.prog_latch_strobe && !le_q)
      begin
         mon_word <= mon_sr;
         mon_cnt <= mon_cnt + 1;
      end
      clk_q <= link.prog_clock;
      le_q <= link.prog_latch_strobe;
      out0_hist_q <= {out0_hist_q[14:0], chan_out[0]}; // Channel 0 history for delay check
   end

   task automatic chk(input bit ok, input string msg);
      comparisons++;
      if (!ok)
      begin
         num_errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Bus write: address and data offered together, released when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      bit ta, tw, tb;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      tb = 1'b0;
      while (!tb)
      begin
         @(negedge i_sys_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r = bresp;
         @(posedge i_sys_clk);
         if (ta)
            awvalid <= 1'h0;
         if (tw)
            wvalid <= 1'h0;
      end
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ta, tr;
      araddr <= a;
      arvalid <= 1'h1;
      tr = 1'b0;
      while (!tr)
      begin
         @(negedge i_sys_clk);
         ta = arvalid && arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge i_sys_clk);
         if (ta)
            arvalid <= 1'h0;
      end
   endtask

   // Send one word and compare what crossed the wire
   task automatic send(input logic [31:0] w);
      logic [1:0] r;
      int n;
      n = mon_cnt;
      wr(`CDDC_HOST_WORD, w, r);
      chk(r === `CDDC_RESP_OKAY, "word write refused");
      for (int k = 0; k < 200 && mon_cnt == n; k++) @(posedge i_sys_clk);
      repeat (3) @(posedge i_sys_clk);
      chk(mon_word === w, "serial word mismatch");
   endtask

   task automatic do_reset();
      i_sys_rst <= 1'h1;
      repeat (10) @(posedge i_sys_clk);
      i_sys_rst <= 1'h0;
      repeat (2) @(posedge i_sys_clk);
      chk(chan_drive === 8'h00 && ref_sel === 1'h0 && link.prog_clock === 1'h0, "reset");
   endtask

   function automatic logic [31:0] chw(input int c, input logic en, input logic [1:0] mx,
      input logic [7:0] dv);
      return {13'h0, mx, en, dv, 4'h0, c[3:0]};
   endfunction

   function automatic logic [31:0] glw(input logic g, input logic rs);
      return {2'h0, rs, 1'h0, g, 23'h0, 4'hE};
   endfunction

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   initial
   begin
      logic [1:0] r;
      logic [31:0] d;
      int c, h, t, e;
      do_reset();
      // Refusals: unmapped address, word while the link is busy
      wr(4'hC, 32'h0, r);
      chk(r === `CDDC_RESP_SLVERR, "unmapped write taken");
      wr(`CDDC_HOST_WORD, 32'h80000000, r);
      wr(`CDDC_HOST_WORD, glw(1'h1, 1'h1), r);
      chk(r === `CDDC_RESP_SLVERR, "busy write taken");
      rd(`CDDC_HOST_STATUS, d, r);
      chk(d[0] === 1'h1 && r === `CDDC_RESP_OKAY, "busy flag low");
      for (int k = 0; k < 60 && d[0] !== 1'h0; k++) rd(`CDDC_HOST_STATUS, d, r);
      chk(d[0] === 1'h0, "busy flag stuck");
      chk(ref_sel === 1'h0, "refused word applied");
      rd(4'hC, d, r);
      chk(r === `CDDC_RESP_SLVERR, "unmapped read taken");
      $display("test refusal done");
      // Reference choice and random words on the wire
      send(glw(1'h1, 1'h1));
      chk(ref_sel === 1'h1, "reference b not selected");
      send(glw(1'h1, 1'h0));
      chk(ref_sel === 1'h0, "reference a not selected");
      for (int k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         d[31:16] = seed;
         seed = lfsr(seed);
         send({d[31:16], seed});
      end
      send(32'h80000000);
      rd(`CDDC_HOST_WORD, d, r);
      chk(d === 32'h80000000 && r === `CDDC_RESP_OKAY, "word readback");
      $display("test word done");
      // Output state table on one random channel
      c = int'(seed[2:0]);
      for (int k = 0; k < 8; k++)
      begin
         send(chw(c, k[0], cddc_pkg::CDDC_MUX_BYPASS, 8'h01));
         send(glw(k[1], 1'h0));
         wr(`CDDC_HOST_CTRL, k[2] ? 32'h0 : 32'h2, r);
         h = 0;
         repeat (16)
         begin
            @(posedge i_sys_clk);
            h += (chan_out[c] === 1'h1);
         end
         t = k[0] & k[1];
         chk(chan_drive === (8'(t) << c), "drive state");
         chk((h > 0) === (t != 0 && k[2]), "output activity");
      end
      wr(`CDDC_HOST_CTRL, 32'h0, r);
      $display("test enables done");
      // Sync with one bypass, two divided and one delayed channel
      send(chw(0, 1'h1, cddc_pkg::CDDC_MUX_BYPASS, 8'h01));
      send(chw(1, 1'h1, cddc_pkg::CDDC_MUX_DIVIDED, 8'h02));
      send(chw(2, 1'h1, cddc_pkg::CDDC_MUX_DIVIDED, 8'h04));
      send(chw(3, 1'h1, cddc_pkg::CDDC_MUX_DELAYED, 8'h01) | 32'h00000050);
      wr(`CDDC_HOST_CTRL, 32'h4, r);
      for (int k = 0; k < 50 && link.sync_n !== 1'h0; k++) @(posedge i_sys_clk);
      h = 0;
      for (int k = 0; k < 200 && link.sync_n === 1'h0; k++)
      begin
         @(posedge i_sys_clk);
         h += (chan_out[0] === 1'h1);
      end
      chk(h > 0, "bypass stopped by sync");
      chk(chan_out[2:1] === 2'h0, "divided output high in sync");
      t = 0;
      for (int k = 0; k < 100 && chan_out[2:1] === 2'h0; k++)
      begin
         @(posedge i_sys_clk);
         t++;
      end
      chk(chan_out[2:0] === 3'h7, "divided outputs not together");
      chk(t >= `CDDC_SYNC_LAT * 4, "restart too early");
      // Rises over 44 cycles of a 4-cycle reference; channel 3 lags channel 0 by 5
      h = 0;
      t = 0;
      e = 0;
      for (int k = 0; k < 44; k++)
      begin
         d[1:0] = chan_out[2:1];
         @(posedge i_sys_clk);
         h += int'(chan_out[1] && !d[0]);
         t += int'(chan_out[2] && !d[1]);
         e += int'(chan_out[3] !== out0_hist_q[4]);
      end
      chk(h == 44 / (4 * 2) && t == 44 / (4 * 4), "divided rate wrong");
      chk(e == 0, "delay steps wrong");
      $display("test sync done");
      // Register 0 reset bit ignores the rest, then a mid-run reset
      send(32'h8001FFF0);
      chk(chan_drive === 8'h00, "defaults not reloaded");
      send(glw(1'h1, 1'h1));
      do_reset();
      chk(ref_sel === 1'h0, "reference kept over reset");
      $display("test reset done");
      end_sim();
   end
endmodule
